// *** pkg/chroma_blend_pkg.sv ***
// constants, register map and state codes of the chroma upscale blender
package chroma_blend_pkg;
  localparam int APB_AW = 12;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] ALPHA_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  // output_control_register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OVL_BIT = 4;
  localparam int CTRL_EXT_BIT = 5;
  localparam int CTRL_FINE_BIT = 6;
  localparam int CTRL_RUN_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // alpha register fields
  localparam int ALPHA_CLR_LSB = 0;
  localparam int ALPHA_SET_LSB = 8;
  localparam logic [31:0] ALPHA_RESET = 32'h0000_0000;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RSVD_BIT = 1;
  localparam int STAT_ODD_BIT = 2;
  localparam int STAT_WIDTH_LSB = 16;
  // operating modes
  localparam logic [1:0] FMT_COSITED = 2'h0;
  localparam logic [1:0] FMT_INTER = 2'h1;
  localparam logic [1:0] FMT_420 = 2'h2;
  localparam logic [1:0] FMT_RSVD = 2'h3;
  localparam int MODE_UP_BIT = 2;
  localparam logic [3:0] MODE_STREAM = 4'h8;
  localparam logic [3:0] MODE_MSG = 4'h9;
  // four-tap weights, first tap in the top six bits
  typedef logic [23:0] taps_t;
  localparam taps_t TAPS_COPY = {6'h00, 6'h10, 6'h00, 6'h00};
  localparam taps_t TAPS_CONV = {6'h3f, 6'h05, 6'h0d, 6'h3f};
  localparam taps_t TAPS_HALF = {6'h3f, 6'h0d, 6'h05, 6'h3f};
  localparam taps_t TAPS_UPS = {6'h3d, 6'h13, 6'h13, 6'h3d};
  localparam logic [2:0] SH16 = 3'h4;
  localparam logic [2:0] SH32 = 3'h5;
  localparam int BLEND_SHIFT = 7;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_LOAD = 5'h02,
    S_EMIT = 5'h04,
    S_LEAD = 5'h08,
    S_RAW = 5'h10
  } state_e;
endpackage

// *** verilog/video_chroma_upscale_blend.sv ***
// video chroma conversion, 2x line upscaler and overlay blender behind apb
//
// Operation
// - modes 0,1,2: refresh from co-sited, interspersed, 4:2:0; 3 reserved
// - modes 4,5,6: same formats with 2x horizontal upscale; 7 reserved
// - mode 8: raw byte stream with lead pulse and active level
// - mode 9: raw message framed by start and end strobes; A..F reserved
// - overlay bit decides whether overlay merges in refresh modes
// - interspersed chroma made co-sited with (-1,5,13,-1)/16
// - 4:2:0 chroma line serves two luma lines, then converted
// - upscale doubles pixels per line, never the line count
// - upscaled luma: coincident copied, in-between (-3,19,19,-3)/32
// - co-sited chroma upscaled exactly like luma
// - interspersed upscale: half offset (-1,13,5,-1), 1.5 offset (-1,5,13,-1)
// - missing edge taps made by mirroring first and last pixels
// - edge outputs 2, 2N-2 and 2N use the listed mirrored taps
// - fine blending only with extended and fine bits, else 25% steps
// - U lsb flags first luma pixel, V lsb flags second
// - flag 0 picks clear alpha, flag 1 picks set alpha
// - U flag covers U, Y0 and V; V flag only Y1
// - alpha msb set: output is overlay component alone
// - otherwise image plus alpha[6:0] times difference shifted by 7
// - overlay never upscaled; supplied at output resolution
`timescale 1ns/1ps
module video_chroma_upscale_blend
  import chroma_blend_pkg::*;
#(
  parameter int MAXW = 1024
) (
  // clock and reset
  input logic clk,
  input logic rstn,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [APB_AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory fetch: one luma pixel per word, chroma on even pixels
  input logic inValid,
  output logic inReady,
  input logic [7:0] inY,
  input logic [7:0] inU,
  input logic [7:0] inV,
  input logic inLast,
  // overlay pixel pair at output resolution
  input logic olValid,
  output logic olReady,
  input logic [7:0] olY0,
  input logic [7:0] olY1,
  input logic [7:0] olU,
  input logic [7:0] olV,
  // byte-wide video output
  output logic outValid,
  output logic [7:0] outByte,
  output logic streamLead,
  output logic streamActive,
  output logic messageStartStrobe,
  output logic messageEndStrobe
);
  localparam int AW = $clog2(MAXW) + 1;
  localparam int IW = AW + 2;
  localparam logic signed [IW-1:0] ONE = IW'(1);
  localparam logic signed [IW-1:0] TWO = IW'(2);

  typedef struct packed {
    state_e st;
    logic [3:0] mode;
    logic olEn;
    logic ext;
    logic fine;
    logic run;
    logic [7:0] aClr;
    logic [7:0] aSet;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic inReady;
    logic olReady;
    logic [AW-1:0] wIdx;
    logic [AW-1:0] nPix;
    logic [AW-1:0] oIdx;
    logic [1:0] ph;
    logic lineOdd;
    logic [7:0] oY0;
    logic [7:0] oY1;
    logic [7:0] oU;
    logic [7:0] oV;
    logic [7:0] outByte;
    logic outValid;
    logic streamLead;
    logic streamActive;
    logic msgStart;
    logic msgEnd;
  } state_s;

  localparam state_s RST = '{st: S_IDLE, mode: CTRL_RESET[3:0],
    aClr: ALPHA_RESET[7:0], aSet: ALPHA_RESET[15:8], default: '0};

  state_s s_q, s_d;

  // line memories; chroma kept across a 4:2:0 line pair
  logic [7:0] yMem [MAXW];
  logic [7:0] uMem [MAXW/2];
  logic [7:0] vMem [MAXW/2];

  logic accept, take, go, yWr, cWr, up, videoMode, modeRsvd, lastPair;
  logic [1:0] fmt;
  logic signed [IW-1:0] kIdx, qIdx, base, cnt, lumaLen;
  taps_t w;
  logic [2:0] sh;
  logic [AW-2:0] idx;
  logic [7:0] smp, img, ovC, ovU, ovV, alpha, outPix, yCoin;
  logic signed [16:0] acc, rnd;
  logic [6:0] coef;
  logic signed [9:0] diff;
  logic signed [17:0] prod, blend;
  logic flag;
  logic [31:0] rd;

  function automatic logic [AW-2:0] mirror(input logic signed [IW-1:0] j,
      input logic signed [IW-1:0] i, input logic signed [IW-1:0] n);
    logic signed [IW-1:0] r;
    r = j;
    if (j >= n) begin
      // the last output reuses the end pixel, the one before it does not
      r = (j == n && i == n - ONE) ? n - ONE : n - TWO;
    end
    if (r < 0) begin
      r = '0;
    end
    return r[AW-2:0];
  endfunction

  assign up = s_q.mode[MODE_UP_BIT];
  assign fmt = s_q.mode[1:0];
  assign videoMode = !s_q.mode[3] && fmt != FMT_RSVD;
  assign modeRsvd = s_q.mode[3] ? s_q.mode > MODE_MSG : fmt == FMT_RSVD;
  assign accept = inValid && s_q.inReady;
  assign take = olValid && s_q.olReady;
  assign go = s_q.st == S_EMIT && (s_q.ph != 2'h0 || !s_q.olEn || take);
  assign yWr = accept && s_q.st == S_LOAD && s_q.wIdx < AW'(MAXW);
  // second line of a 4:2:0 pair keeps the stored chroma
  assign cWr = yWr && !s_q.wIdx[0] && !(fmt == FMT_420 && s_q.lineOdd);
  assign yCoin = yMem[s_q.oIdx[AW-2:0]];

  always_ff @(posedge clk) begin
    if (yWr) begin
      yMem[s_q.wIdx[AW-2:0]] <= inY;
    end
    if (cWr) begin
      uMem[s_q.wIdx[AW-2:1]] <= inU;
      vMem[s_q.wIdx[AW-2:1]] <= inV;
    end
  end

  // one component per cycle: U, Y0, V, Y1
  always_comb begin
    kIdx = IW'({s_q.oIdx, s_q.ph[1]});
    qIdx = IW'(s_q.oIdx);
    w = TAPS_COPY;
    sh = SH16;
    base = kIdx;
    cnt = IW'(s_q.nPix);
    if (s_q.ph[0]) begin
      if (up) begin
        base = kIdx >>> 1;
        if (kIdx[0]) begin
          w = TAPS_UPS;
          sh = SH32;
        end
      end
    end else begin
      cnt = (IW'(s_q.nPix) + ONE) >>> 1;
      base = qIdx;
      if (fmt == FMT_COSITED) begin
        if (up) begin
          base = qIdx >>> 1;
          if (qIdx[0]) begin
            w = TAPS_UPS;
            sh = SH32;
          end
        end
      end else if (!up) begin
        base = qIdx - ONE;
        w = TAPS_CONV;
      end else if (qIdx[0]) begin
        base = qIdx >>> 1;
        w = TAPS_HALF;
      end else begin
        base = (qIdx >>> 1) - ONE;
        w = TAPS_CONV;
      end
    end
    acc = '0;
    idx = '0;
    smp = '0;
    for (int t = 0; t < 4; t++) begin
      idx = mirror(base + IW'(t) - ONE, base, cnt);
      if (s_q.ph[0]) begin
        smp = yMem[idx];
      end else if (s_q.ph[1]) begin
        smp = vMem[idx[AW-3:0]];
      end else begin
        smp = uMem[idx[AW-3:0]];
      end
      acc = acc + $signed(w[23-6*t -: 6]) * $signed({9'h000, smp});
    end
    // rounding and saturation keep negative taps from wrapping
    rnd = (acc + (17'sh0_0001 <<< (sh - 3'h1))) >>> sh;
    if (rnd < 0) begin
      img = 8'h00;
    end else if (rnd > 17'sh0_00ff) begin
      img = 8'hff;
    end else begin
      img = rnd[7:0];
    end
  end

  // overlay is taken per output pair as is, never resampled
  always_comb begin
    ovU = (s_q.ph == 2'h0) ? olU : s_q.oU;
    ovV = (s_q.ph == 2'h0) ? olV : s_q.oV;
    case (s_q.ph)
      2'h0: ovC = ovU;
      2'h1: ovC = s_q.oY0;
      2'h2: ovC = s_q.oV;
      default: ovC = s_q.oY1;
    endcase
    if (s_q.ph == 2'h0) begin
      ovC = olU;
    end
    flag = (s_q.ph == 2'h3) ? ovV[0] : ovU[0];
    alpha = flag ? s_q.aSet : s_q.aClr;
    // legacy path keeps only quarter steps of alpha
    coef = (s_q.ext && s_q.fine) ? alpha[6:0] : {alpha[6:5], 5'h00};
    diff = $signed({2'h0, ovC}) - $signed({2'h0, img});
    prod = $signed({11'h000, coef}) * $signed({{8{diff[9]}}, diff});
    blend = $signed({10'h000, img}) + (prod >>> BLEND_SHIFT);
    if (!s_q.olEn) begin
      outPix = img;
    end else if (alpha[7]) begin
      outPix = ovC;
    end else begin
      outPix = blend[7:0];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.outValid = 1'b0;
    s_d.streamLead = 1'b0;
    s_d.msgStart = 1'b0;
    s_d.msgEnd = 1'b0;
    lumaLen = up ? IW'(s_q.nPix) <<< 1 : IW'(s_q.nPix);
    lastPair = (IW'(s_q.oIdx) <<< 1) + TWO >= lumaLen;
    case (s_q.st)
      S_IDLE: begin
        if (s_q.run) begin
          if (videoMode) begin
            s_d.st = S_LOAD;
            s_d.wIdx = '0;
            s_d.lineOdd = 1'b0;
            s_d.inReady = 1'b1;
          end else if (s_q.mode == MODE_STREAM) begin
            s_d.st = S_LEAD;
            s_d.streamLead = 1'b1;
          end else if (s_q.mode == MODE_MSG) begin
            s_d.st = S_LEAD;
            s_d.msgStart = 1'b1;
          end
        end
      end
      S_LEAD: begin
        s_d.st = S_RAW;
        s_d.inReady = 1'b1;
        s_d.streamActive = s_q.mode == MODE_STREAM;
      end
      S_RAW: begin
        if (accept) begin
          s_d.outByte = inY;
          s_d.outValid = 1'b1;
        end
        if (s_q.mode == MODE_MSG && accept && inLast) begin
          s_d.msgEnd = 1'b1;
          s_d.st = S_IDLE;
          s_d.inReady = 1'b0;
          s_d.run = 1'b0;
        end else if (s_q.mode == MODE_STREAM && !s_q.run) begin
          s_d.st = S_IDLE;
          s_d.inReady = 1'b0;
          s_d.streamActive = 1'b0;
        end
      end
      S_LOAD: begin
        if (accept) begin
          s_d.wIdx = s_q.wIdx + AW'(1);
          if (inLast) begin
            s_d.nPix = s_q.wIdx + AW'(1);
            s_d.st = S_EMIT;
            s_d.inReady = 1'b0;
            s_d.oIdx = '0;
            s_d.ph = 2'h0;
            s_d.olReady = s_q.olEn;
          end
        end
      end
      S_EMIT: begin
        if (go) begin
          s_d.outByte = outPix;
          s_d.outValid = 1'b1;
          s_d.ph = s_q.ph + 2'h1;
          if (s_q.ph == 2'h0) begin
            s_d.olReady = 1'b0;
            s_d.oY0 = olY0;
            s_d.oY1 = olY1;
            s_d.oU = olU;
            s_d.oV = olV;
          end
          if (s_q.ph == 2'h3) begin
            s_d.oIdx = s_q.oIdx + AW'(1);
            s_d.olReady = s_q.olEn;
            if (lastPair) begin
              s_d.lineOdd = !s_q.lineOdd;
              s_d.olReady = 1'b0;
              s_d.st = s_q.run ? S_LOAD : S_IDLE;
              s_d.wIdx = '0;
              s_d.inReady = s_q.run;
            end
          end
        end
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
    // apb: ready in the first cycle of the access phase
    rd = '0;
    s_d.pready = psel && !penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (paddr == CTRL_OFS) begin
      rd[CTRL_MODE_LSB +: 4] = s_q.mode;
      rd[CTRL_OVL_BIT] = s_q.olEn;
      rd[CTRL_EXT_BIT] = s_q.ext;
      rd[CTRL_FINE_BIT] = s_q.fine;
      rd[CTRL_RUN_BIT] = s_q.run;
    end else if (paddr == ALPHA_OFS) begin
      rd[ALPHA_CLR_LSB +: 8] = s_q.aClr;
      rd[ALPHA_SET_LSB +: 8] = s_q.aSet;
    end else if (paddr == STATUS_OFS) begin
      rd[STAT_BUSY_BIT] = s_q.st != S_IDLE;
      rd[STAT_RSVD_BIT] = modeRsvd;
      rd[STAT_ODD_BIT] = s_q.lineOdd;
      rd[STAT_WIDTH_LSB +: AW] = s_q.nPix;
    end else begin
      s_d.pslverr = s_d.pready;
    end
    if (s_d.pready) begin
      s_d.prdata = rd;
    end
    // a software write lands after the hardware run clear, so it wins
    if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
      if (paddr == CTRL_OFS) begin
        s_d.mode = pwdata[CTRL_MODE_LSB +: 4];
        s_d.olEn = pwdata[CTRL_OVL_BIT];
        s_d.ext = pwdata[CTRL_EXT_BIT];
        s_d.fine = pwdata[CTRL_FINE_BIT];
        s_d.run = pwdata[CTRL_RUN_BIT];
      end else if (paddr == ALPHA_OFS) begin
        s_d.aClr = pwdata[ALPHA_CLR_LSB +: 8];
        s_d.aSet = pwdata[ALPHA_SET_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign inReady = s_q.inReady;
  assign olReady = s_q.olReady;
  assign outValid = s_q.outValid;
  assign outByte = s_q.outByte;
  assign streamLead = s_q.streamLead;
  assign streamActive = s_q.streamActive;
  assign messageStartStrobe = s_q.msgStart;
  assign messageEndStrobe = s_q.msgEnd;

  rsvdIdle_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == S_IDLE && modeRsvd) |=> s_q.st == S_IDLE)
    else $error("reserved mode left idle");
  streamLead_a: assert property (@(posedge clk) disable iff (!rstn)
    streamLead |=> !streamLead ##0 streamActive)
    else $error("stream lead not followed by active level");
  msgEnd_a: assert property (@(posedge clk) disable iff (!rstn)
    messageEndStrobe |-> outValid ##1 (!messageEndStrobe && !inReady))
    else $error("message end without last byte");
  olGate_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == S_EMIT && !s_q.olEn) |-> !olReady)
    else $error("overlay requested while disabled");
  chromaHold_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == S_LOAD && fmt == FMT_420 && s_q.lineOdd) |-> !cWr)
    else $error("4:2:0 chroma overwritten on second line");
  lineToggle_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == S_EMIT && s_d.st != S_EMIT) |=> s_q.lineOdd != $past(s_q.lineOdd))
    else $error("line parity not advanced");
  upCopy_a: assert property (@(posedge clk) disable iff (!rstn)
    (go && up && s_q.ph == 2'h1 && !s_q.olEn) |=> outByte == $past(yCoin))
    else $error("coincident luma not copied");
  olOnly_a: assert property (@(posedge clk) disable iff (!rstn)
    (go && s_q.olEn && alpha[7]) |=> outByte == $past(ovC))
    else $error("opaque alpha not overlay");
  imgOnly_a: assert property (@(posedge clk) disable iff (!rstn)
    (go && s_q.olEn && alpha == 8'h00) |=> outByte == $past(img))
    else $error("zero alpha not image");
  apbReady_a: assert property (@(posedge clk) disable iff (!rstn)
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("apb ready not one cycle");

  upLine_c: cover property (@(posedge clk) disable iff (!rstn)
    s_q.st == S_EMIT && up && lastPair && go && s_q.ph == 2'h3);
  blendLine_c: cover property (@(posedge clk) disable iff (!rstn)
    go && s_q.olEn && !alpha[7] && alpha != 8'h00);
  msgDone_c: cover property (@(posedge clk) disable iff (!rstn) messageEndStrobe);
  streamStop_c: cover property (@(posedge clk) disable iff (!rstn) $fell(streamActive));
endmodule // video_chroma_upscale_blend

// *** verification/fetch_partner.sv ***
// memory fetch and overlay source model feeding the blender
`timescale 1ns/1ps
module fetch_partner (
  // clock and pacing
  input wire logic clk,
  input wire logic slow,
  // fetch side
  input wire logic inReady,
  output logic inValid = 1'b0,
  output logic [7:0] inY = 8'h00,
  output logic [7:0] inU = 8'h00,
  output logic [7:0] inV = 8'h00,
  output logic inLast = 1'b0,
  // overlay side
  input wire logic olReady,
  output logic olValid = 1'b0,
  output logic [7:0] olY0 = 8'h00,
  output logic [7:0] olY1 = 8'h00,
  output logic [7:0] olU = 8'h00,
  output logic [7:0] olV = 8'h00
);
  logic [24:0] fq[$];
  logic [31:0] oq[$];
  logic gap = 1'b0;
  task automatic push(input logic [24:0] w);
    fq.push_back(w);
  endtask
  // one pixel pair per word, flags in the u and v lsb
  task automatic push_ol(input logic [31:0] w);
    oq.push_back(w);
  endtask
  task automatic flush();
    fq.delete();
    oq.delete();
  endtask
  always @(posedge clk) begin
    // slow pacing idles every other cycle to stress the fetch stall path
    gap <= slow & ~gap;
    if (inValid && inReady) void'(fq.pop_front());
    if (olValid && olReady) void'(oq.pop_front());
    // a raised request is held until taken
    if (!(inValid && !inReady && fq.size() > 0)) begin
      if (fq.size() > 0 && !gap) begin
        inValid <= 1'b1;
        {inLast, inY, inU, inV} <= fq[0];
      end else begin
        // released lines toggle so stale data never looks usable
        inValid <= 1'b0;
        {inLast, inY, inU, inV} <= ~{inLast, inY, inU, inV};
      end
    end
    if (!(olValid && !olReady && oq.size() > 0)) begin
      if (oq.size() > 0 && !gap) begin
        olValid <= 1'b1;
        {olV, olU, olY1, olY0} <= oq[0];
      end else begin
        olValid <= 1'b0;
        {olV, olU, olY1, olY0} <= ~{olV, olU, olY1, olY0};
      end
    end
  end
endmodule // fetch_partner

// *** verification/video_chroma_upscale_blend_tb_top.sv ***
// self-checking bench for the chroma upscale blender
`timescale 1ns/1ps
module video_chroma_upscale_blend_tb_top;
  import chroma_blend_pkg::*;
  localparam int N = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, inValid, inReady, inLast, olValid, olReady;
  logic [7:0] inY, inU, inV, olY0, olY1, olU, olV, outByte;
  logic outValid, streamLead, streamActive, messageStartStrobe, messageEndStrobe;
  logic [31:0] seed = 32'h0001_0179;
  logic [8:0] outQ[$];
  logic [8:0] expQ[$];
  int numErrors = 0;
  int checked = 0;
  int leadCnt = 0;
  int startCnt = 0;

  always #5 clk = ~clk;

  video_chroma_upscale_blend #(.MAXW(16)) dut (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .inValid, .inReady, .inY, .inU, .inV, .inLast, .olValid, .olReady, .olY0, .olY1,
    .olU, .olV, .outValid, .outByte, .streamLead, .streamActive, .messageStartStrobe,
    .messageEndStrobe);
  fetch_partner fetch (
    .clk, .slow, .inReady, .inValid, .inY, .inU, .inV, .inLast, .olReady, .olValid,
    .olY0, .olY1, .olU, .olV);

  always @(posedge clk) begin
    if (rstn && outValid === 1'b1) outQ.push_back({messageEndStrobe, outByte});
    if (streamLead === 1'b1) leadCnt++;
    if (messageStartStrobe === 1'b1) startCnt++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // missing edge taps mirror about the first and last pixel
  function automatic int mir(int i, int n, bit last);
    if (i < 0) return 0;
    if (i == n) return last ? n - 1 : n - 2;
    if (i > n) return n - 2;
    return i;
  endfunction

  function automatic int upf(int a[16], int n, int q);
    int k;
    int s;
    bit l;
    k = q / 2;
    l = (q == 2 * n - 1);
    if (q % 2 == 0) return a[k];
    s = 19 * (a[k] + a[mir(k + 1, n, l)]) - 3 * (a[mir(k - 1, n, l)] + a[mir(k + 2, n, l)]);
    s = (s + 16) >>> 5;
    return s < 0 ? 0 : (s > 255 ? 255 : s);
  endfunction

  function automatic int tap4(int a[16], int b, int w0, int w1, int w2, int w3);
    int s;
    int n;
    bit l;
    n = N / 2;
    l = (b == n - 1);
    s = w0 * a[mir(b - 1, n, l)] + w1 * a[mir(b, n, l)];
    s = s + w2 * a[mir(b + 1, n, l)] + w3 * a[mir(b + 2, n, l)];
    s = (s + 8) >>> 4;
    return s < 0 ? 0 : (s > 255 ? 255 : s);
  endfunction

  // chroma for output pair q: copy, co-sited upscale or interspersed filters
  function automatic int cfil(int a[16], bit up, bit isp, int q);
    int m;
    m = q / 2;
    if (!isp) return up ? upf(a, N / 2, q) : a[q];
    if (!up) return tap4(a, q - 1, -1, 5, 13, -1);
    if (q % 2) return tap4(a, m, -1, 13, 5, -1);
    return tap4(a, m - 1, -1, 5, 13, -1);
  endfunction

  function automatic int blend(int img, int ov, logic [7:0] a, bit fine);
    if (!fine) a = {a[7:5], 5'h00};
    if (a[7]) return ov;
    return img + ((int'(a[6:0]) * (ov - img)) >>> 7);
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) numErrors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    fetch.flush();
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    outQ.delete();
    expQ.delete();
    leadCnt = 0;
    startCnt = 0;
  endtask

  task automatic collect(input string name);
    int n;
    n = 0;
    while (outQ.size() < expQ.size() && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    chk_word(32'(outQ.size()), 32'(expQ.size()));
    for (int i = 0; i < expQ.size() && i < outQ.size(); i++) chk_byte(outQ[i], expQ[i]);
    $display("test %s done", name);
  endtask

  task automatic run_raw(input logic [3:0] mode, input int n);
    logic [31:0] r;
    logic [31:0] c;
    logic e;
    bit last;
    do_reset();
    for (int i = 0; i < n; i++) begin
      r = rnd();
      last = (mode == MODE_MSG) && (i == n - 1);
      fetch.push({last, r[23:0]});
      expQ.push_back({last, r[23:16]});
    end
    c = 32'h0000_0080 | 32'(mode);
    apb(1, CTRL_OFS, c, r, e);
    collect("raw");
    chk_word(32'(leadCnt), 32'(mode == MODE_STREAM));
    chk_word(32'(startCnt), 32'(mode == MODE_MSG));
    chk_word(32'(streamActive), 32'(mode == MODE_STREAM));
    apb(0, CTRL_OFS, '0, r, e);
    // a finished message clears the run bit by itself
    chk_word(r, mode == MODE_MSG ? 32'(mode) : c);
    apb(1, CTRL_OFS, '0, r, e);
  endtask

  task automatic run_video(input logic [3:0] mode, input bit ovl, input bit fine, input bit sl);
    int y[16];
    int cu[16];
    int cv[16];
    int np;
    int im[4];
    logic [31:0] r;
    logic [7:0] a0;
    logic [7:0] a1;
    logic e;
    bit up;
    bit isp;
    int nl;
    do_reset();
    slow <= sl;
    up = mode[MODE_UP_BIT];
    isp = mode[1:0] != FMT_COSITED;
    // a 4:2:0 line pair runs on the chroma of its first line only
    nl = mode[1:0] == FMT_420 ? 2 : 1;
    apb(1, ALPHA_OFS, 32'h0000_905a, r, e);
    for (int l = 0; l < nl; l++) begin
    for (int i = 0; i < N; i++) begin
      r = rnd();
      y[i] = r[23:16];
      if (i % 2 == 0 && l == 0) cu[i / 2] = r[15:8];
      if (i % 2 == 0 && l == 0) cv[i / 2] = r[7:0];
      fetch.push({i == N - 1, r[23:0]});
    end
    np = up ? N : N / 2;
    for (int p = 0; p < np; p++) begin
      im[0] = cfil(cu, up, isp, p);
      im[1] = up ? upf(y, N, 2 * p) : y[2 * p];
      im[2] = cfil(cv, up, isp, p);
      im[3] = up ? upf(y, N, 2 * p + 1) : y[2 * p + 1];
      if (ovl) begin
        r = rnd();
        fetch.push_ol(r);
        a0 = r[16] ? 8'h90 : 8'h5a;
        a1 = r[24] ? 8'h90 : 8'h5a;
        im[0] = blend(im[0], r[23:16], a0, fine);
        im[1] = blend(im[1], r[7:0], a0, fine);
        im[2] = blend(im[2], r[31:24], a0, fine);
        im[3] = blend(im[3], r[15:8], a1, fine);
      end
      for (int k = 0; k < 4; k++) expQ.push_back(9'(im[k]));
    end
    end
    r = 32'h0000_00a0 | 32'(mode) | (32'(ovl) << CTRL_OVL_BIT) | (32'(fine) << CTRL_FINE_BIT);
    apb(1, CTRL_OFS, r, r, e);
    collect("video");
    apb(1, CTRL_OFS, '0, r, e);
    slow <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    numErrors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic e;
    do_reset();
    apb(0, CTRL_OFS, '0, r, e);
    chk_word(r, CTRL_RESET);
    apb(0, ALPHA_OFS, '0, r, e);
    chk_word(r, ALPHA_RESET);
    apb(1, ALPHA_OFS, 32'hffff_ffff, r, e);
    apb(0, ALPHA_OFS, '0, r, e);
    chk_word(r, 32'h0000_ffff);
    apb(0, 12'h00c, '0, r, e);
    chk_word({r[30:0], e}, 32'h0000_0001);
    $display("test registers done");
    for (int m = 0; m < 16; m++) begin
      if (m == 3 || m == 7 || m > 9) begin
        apb(1, CTRL_OFS, 32'h0000_0080 | 32'(m), r, e);
        apb(0, STATUS_OFS, '0, r, e);
        chk_word(32'(r[STAT_RSVD_BIT]), 32'h0000_0001);
      end
    end
    chk_word(32'(outQ.size()), 32'h0000_0000);
    $display("test reserved done");
    run_raw(MODE_STREAM, 6);
    run_raw(MODE_MSG, 5);
    // even line width throughout
    run_video(4'h0, 1'b0, 1'b1, 1'b0);
    run_video(4'h4, 1'b0, 1'b0, 1'b1);
    run_video(4'h0, 1'b1, 1'b1, 1'b1);
    run_video(4'h4, 1'b1, 1'b0, 1'b0);
    run_video(4'h1, 1'b0, 1'b0, 1'b0);
    run_video(4'h2, 1'b0, 1'b0, 1'b1);
    run_video(4'h5, 1'b0, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // video_chroma_upscale_blend_tb_top
